// *** pfsu_top.sv ***
/*
 * Pin-function select for the five upper bits of the general-purpose I/O
 * control register, with APB access and a small general-purpose data path.
 * Assumes a zero-wait APB master and pad inputs synchronous to sys_clk.
 */
// Contract
// (RL1) Bit 31 clear: pin carries sa_addr_bit15; set: GPIO line 31 with pull-up.
// (RL2) Bit 30 clear: pin carries sa_addr_bit14; set: GPIO line 30 with pull-up.
// (RL3) Bit 29 clear: pin carries sa_addr_bit13; set: GPIO line 29 with pull-up.
// (RL4) Bit 28 clear: pin carries pci_grant_2_n; set: GPIO line 28 with pull-up.
// (RL5) Bit 27 clear: pin carries pci_grant_1_n; set: GPIO line 27 with pull-up.
// (RL6) GPIO pins isolate normal signal; isolated grants held deasserted internally.
`timescale 1ns/100ps
`include "pfsu_defines.svh"

module pfsu_top
	import pfsu_pkg::*;
#(
	parameter int PINS = 5
)
(
	// Clock and reset.
	input  wire logic            sys_clk,
	input  wire logic            rst,
	// APB slave.
	input  pfsu_apb_req_t        apb_req,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Normal-function sources.
	input  wire logic            sa_addr_bit15,
	input  wire logic            sa_addr_bit14,
	input  wire logic            sa_addr_bit13,
	input  wire logic            pci_grant_2_n,
	input  wire logic            pci_grant_1_n,
	// Shared pins, index 0 is line 27.
	input  wire logic [PINS-1:0] pad_in,
	output pfsu_pad_t [PINS-1:0] pad,
	// Grant lines that the arbiter must treat as unusable.
	output logic [1:0]           grant_blocked
);

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic [31:0]     select;
		logic [PINS-1:0] gp_out;
		logic [PINS-1:0] gp_oe;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic [1:0]      grant_blocked;
	} pfsu_state_t;

	pfsu_state_t     st_q;
	pfsu_state_t     st_d;
	logic [PINS-1:0] gp_in;
	logic [PINS-1:0] func_out;
	logic [PINS-1:0] gp_sel;
	logic            setup;
	logic            access;

	// Bus phase decode and the five steering bits of the select register.
	assign setup  = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable && st_q.pready;
	assign gp_sel = st_q.select[`PFSU_FIELD_HI:`PFSU_FIELD_LO];

	// Normal functions in field order, line 27 in the lowest slot.
	assign func_out = {sa_addr_bit15, sa_addr_bit14, sa_addr_bit13, pci_grant_2_n, pci_grant_1_n};

	// ****************************************************************
	// Register access and next state.
	// ****************************************************************
	// Read data and the error flag are settled in the setup cycle so that the
	// access phase completes at once; this keeps every bus output a flop.
	always_comb
	begin
		st_d        = st_q;
		st_d.pready = setup;
		if (setup)
		begin
			st_d.pslverr = 1'b0;
			case (apb_req.paddr)
				`PFSU_SELECT_OFF: st_d.prdata = st_q.select;
				`PFSU_GP_OUT_OFF: st_d.prdata = {st_q.gp_out, 27'h0000000};
				`PFSU_GP_OE_OFF:  st_d.prdata = {st_q.gp_oe, 27'h0000000};
				`PFSU_GP_IN_OFF:  st_d.prdata = {gp_in, 27'h0000000};
				default:
				begin
					st_d.prdata  = 32'h00000000;
					st_d.pslverr = 1'b1;
				end
			endcase
		end
		if (access && apb_req.pwrite)
		begin
			case (apb_req.paddr)
				`PFSU_SELECT_OFF: st_d.select = apb_req.pwdata;
				`PFSU_GP_OUT_OFF: st_d.gp_out = apb_req.pwdata[`PFSU_FIELD_HI:`PFSU_FIELD_LO];
				`PFSU_GP_OE_OFF:  st_d.gp_oe  = apb_req.pwdata[`PFSU_FIELD_HI:`PFSU_FIELD_LO];
				default:          st_d.select = st_q.select;
			endcase
		end
		// (RL6) grants withheld from arbiter
		st_d.grant_blocked = gp_sel[1:0];
	end

	// One register stage holds all block state; reset selects the normal functions.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q               <= '0;
			st_q.select        <= `PFSU_SELECT_RST;
			st_q.gp_out        <= `PFSU_GP_OUT_RST;
			st_q.gp_oe         <= `PFSU_GP_OE_RST;
		end
		else
			st_q <= st_d;
	end

	// Bus outputs come straight from the state flops.
	assign prdata        = st_q.prdata;
	assign pready        = st_q.pready;
	assign pslverr       = st_q.pslverr;
	assign grant_blocked = st_q.grant_blocked;

	// ****************************************************************
	// Pin cells.
	// ****************************************************************
	// (RL1) (RL2) (RL3) (RL4) (RL5) per-pin function mux
	// (RL6) normal signal isolated when selected
	generate
		for (genvar i = 0; i < PINS; i++)
		begin : g_pin
			pfsu_pin_cell u_cell (
				.sys_clk   (sys_clk),
				.rst       (rst),
				.gp_select (gp_sel[i]),
				.func_out  (func_out[i]),
				.gp_out    (st_q.gp_out[i]),
				.gp_oe     (st_q.gp_oe[i]),
				.pad_in    (pad_in[i]),
				.pad       (pad[i]),
				.gp_in     (gp_in[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Checks.
	// ****************************************************************
	// The pads still show their reset drive at the edge after release, so checks
	// that expect the normal drive, all but a_pin27_grant, start only once a full edge has passed out of reset.

	// Pin routing, checked one edge after the select, source or GPIO value.
	a_pin31_normal: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		!$past(rst) && !gp_sel[4] |=> (pad[4].out == $past(sa_addr_bit15)) && pad[4].oe && !pad[4].pu)
		else $error("Pin 31 does not carry the address bit.");
	a_pin31_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		gp_sel[4] |=> pad[4].pu && (pad[4].out == $past(st_q.gp_out[4])))
		else $error("Pin 31 not in general-purpose mode.");
	a_pin30_route: assert property (@(posedge sys_clk) disable iff (rst) // RL2
		!$past(rst) |=> (pad[3].out == ($past(gp_sel[3]) ? $past(st_q.gp_out[3]) : $past(sa_addr_bit14))))
		else $error("Pin 30 routing wrong.");
	a_pin29_route: assert property (@(posedge sys_clk) disable iff (rst) // RL3
		!$past(rst) |=> (pad[2].pu == $past(gp_sel[2])) && (pad[2].oe == ($past(gp_sel[2]) ? $past(st_q.gp_oe[2]) : 1'b1)))
		else $error("Pin 29 drive or pull-up wrong.");
	a_pin28_grant: assert property (@(posedge sys_clk) disable iff (rst) // RL4
		!$past(rst) && !gp_sel[1] |=> (pad[1].out == $past(pci_grant_2_n)) && pad[1].oe)
		else $error("Pin 28 does not carry grant 2.");
	a_pin27_grant: assert property (@(posedge sys_clk) disable iff (rst) // RL5
		!gp_sel[0] |=> (pad[0].out == $past(pci_grant_1_n)) && !pad[0].pu)
		else $error("Pin 27 does not carry grant 1.");
	a_grant_isolate: assert property (@(posedge sys_clk) disable iff (rst) // RL6
		gp_sel[1] && !st_q.gp_out[1] |=> grant_blocked[1] && (pad[1].out == 1'b0))
		else $error("Isolated grant leaked or not blocked.");
	a_apb_write_select: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		access && apb_req.pwrite && (apb_req.paddr == `PFSU_SELECT_OFF)
		|=> (st_q.select == $past(apb_req.pwdata)) ##1 (pad[4].pu == st_q.select[31]))
		else $error("Select write did not reach pin 31.");

	// Drive enable, pull-up and output of the lines; with the checks above, every line in both modes.
	a_pin31_drive: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		gp_sel[4] |=> (pad[4].oe == $past(st_q.gp_oe[4])))
		else $error("Pin 31 drive enable wrong in general-purpose mode.");
	a_pin30_pull: assert property (@(posedge sys_clk) disable iff (rst) // RL2
		!$past(rst) |=> (pad[3].pu == $past(gp_sel[3])) && (pad[3].oe == ($past(gp_sel[3]) ? $past(st_q.gp_oe[3]) : 1'b1)))
		else $error("Pin 30 drive or pull-up wrong.");
	a_pin30_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL2
		gp_sel[3] |=> pad[3].pu && (pad[3].out == $past(st_q.gp_out[3])))
		else $error("Pin 30 not in general-purpose mode.");
	a_pin29_out: assert property (@(posedge sys_clk) disable iff (rst) // RL3
		!$past(rst) |=> (pad[2].out == ($past(gp_sel[2]) ? $past(st_q.gp_out[2]) : $past(sa_addr_bit13))))
		else $error("Pin 29 routing wrong.");
	a_pin29_normal: assert property (@(posedge sys_clk) disable iff (rst) // RL3
		!$past(rst) && !gp_sel[2] |=> (pad[2].out == $past(sa_addr_bit13)) && pad[2].oe)
		else $error("Pin 29 does not carry the address bit.");
	a_pin28_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL4
		gp_sel[1] |=> pad[1].pu && (pad[1].out == $past(st_q.gp_out[1])) && (pad[1].oe == $past(st_q.gp_oe[1])))
		else $error("Pin 28 not in general-purpose mode.");
	a_pin28_normal_pu: assert property (@(posedge sys_clk) disable iff (rst) // RL4
		!$past(rst) && !gp_sel[1] |=> !pad[1].pu)
		else $error("Pin 28 pull-up applied in normal mode.");
	a_pin27_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL5
		gp_sel[0] |=> pad[0].pu && (pad[0].out == $past(st_q.gp_out[0])) && (pad[0].oe == $past(st_q.gp_oe[0])))
		else $error("Pin 27 not in general-purpose mode.");
	a_pin27_drive: assert property (@(posedge sys_clk) disable iff (rst) // RL5
		!$past(rst) && !gp_sel[0] |=> pad[0].oe)
		else $error("Pin 27 not driven in normal mode.");

	// Grant isolation and the select register itself.
	a_grant1_isolate: assert property (@(posedge sys_clk) disable iff (rst) // RL6
		gp_sel[0] |=> grant_blocked[0] && (pad[0].out == $past(st_q.gp_out[0])))
		else $error("Isolated grant 1 leaked or not blocked.");
	a_grant_follow: assert property (@(posedge sys_clk) disable iff (rst) // RL6
		!$past(rst) |=> (grant_blocked == $past(gp_sel[1:0])))
		else $error("Grant block flags do not follow the selection.");
	a_select_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		!(access && apb_req.pwrite && (apb_req.paddr == `PFSU_SELECT_OFF)) |=> $stable(st_q.select))
		else $error("Select register changed without a write.");

endmodule

// *** pfsu_defines.svh ***
/*
 * Register offsets, field positions and reset values of the upper pin-function
 * select block. Assumes it is included by bare name from the top module, the pin cell and the bench.
 */
`ifndef PFSU_DEFINES_SVH
`define PFSU_DEFINES_SVH

// ****************************************************************
// Register map (byte addresses on the APB).
// ****************************************************************
`define PFSU_SELECT_OFF   12'h048
`define PFSU_GP_OUT_OFF   12'h04C
`define PFSU_GP_OE_OFF    12'h050
`define PFSU_GP_IN_OFF    12'h054

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define PFSU_FIELD_LO     27
`define PFSU_FIELD_HI     31
`define PFSU_SELECT_RST   32'h00000000
`define PFSU_GP_OUT_RST   5'h00
`define PFSU_GP_OE_RST    5'h00

`endif

// *** pfsu_pkg.sv ***
/*
 * Types shared by the pin-function select block and its pin cells.
 * Assumes pfsu_defines.svh sits in the same folder.
 */
package pfsu_pkg;

	// APB request from the master, grouped as one carrier.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pfsu_apb_req_t;

	// Drive of one shared package pin.
	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
	} pfsu_pad_t;

endpackage

// *** pfsu_pin_cell.sv ***
/*
 * One shared package pin: picks the normal function or the general-purpose
 * line, applies the pull-up in general-purpose mode, and samples the pad.
 * Assumes the pad input is synchronous to sys_clk.
 */
`timescale 1ns/100ps
`include "pfsu_defines.svh"

module pfsu_pin_cell
	import pfsu_pkg::*;
(
	// Clock and reset.
	input  wire logic      sys_clk,
	input  wire logic      rst,
	// Selection and the two sources.
	input  wire logic      gp_select,
	input  wire logic      func_out,
	input  wire logic      gp_out,
	input  wire logic      gp_oe,
	// Pad side.
	input  wire logic      pad_in,
	output pfsu_pad_t      pad,
	output logic           gp_in
);

	typedef struct packed {
		pfsu_pad_t pad;
		logic      gp_in;
	} pfsu_cell_state_t;

	pfsu_cell_state_t st_q;
	pfsu_cell_state_t st_d;

	// (RL1) (RL2) (RL3) (RL4) (RL5) (RL6) function or GPIO
	// Mux the pin; the normal function always drives while it owns the pin.
	always_comb
	begin
		st_d = st_q;
		if (gp_select)
		begin
			st_d.pad.out = gp_out;
			st_d.pad.oe  = gp_oe;
			st_d.pad.pu  = 1'b1;
		end
		else
		begin
			st_d.pad.out = func_out;
			st_d.pad.oe  = 1'b1;
			st_d.pad.pu  = 1'b0;
		end
		st_d.gp_in = pad_in;
	end

	// Registered so that every pad drive is glitch free.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign pad   = st_q.pad;
	assign gp_in = st_q.gp_in;

	// The pull-up follows the selection exactly one cycle later.
	a_cell_pullup_follow: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		##1 (pad.pu == $past(gp_select))) else $error("Pin pull-up does not follow selection.");

endmodule

// *** pfsu_pad_model.sv ***
/*
 * Model of the five shared package pins seen from the board side.
 * Assumes pin levels settle on the rising edge of sys_clk.
 */
`timescale 1ns/100ps

module pfsu_pad_model
	import pfsu_pkg::*;
(
	// Clock.
	input  wire logic       sys_clk,
	// Drive from the block and level back.
	input  pfsu_pad_t [4:0] pad,
	output logic [4:0]      pad_in
);
	// pull-up level
	// A released pin with no pull-up toggles, so a stale level cannot pass as valid.
	always @(posedge sys_clk)
		for (int i = 0; i < 5; i++)
			pad_in[i] <= pad[i].oe ? pad[i].out : (pad[i].pu ? 1'b1 : ~pad_in[i]);

	initial pad_in = 5'h00;
endmodule

// *** pin_function_select_upper_test.sv ***
/*
 * Self-checking bench of the upper pin-function select block.
 * Assumes the pad model file and the design files are compiled first.
 */
`timescale 1ns/100ps
`include "pfsu_defines.svh"

module pin_function_select_upper_test
	import pfsu_pkg::*;
;
	logic            sys_clk;
	logic            rst;
	pfsu_apb_req_t   apb_req;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic [4:0]      src;
	logic [4:0]      pad_in;
	pfsu_pad_t [4:0] pad;
	logic [1:0]      grant_blocked;
	logic [31:0]     rd;
	logic            er;
	int              n_fail = 0;
	int              cmp_count = 0;

	pfsu_top DUT (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sa_addr_bit15(src[4]), .sa_addr_bit14(src[3]), .sa_addr_bit13(src[2]),
		.pci_grant_2_n(src[1]), .pci_grant_1_n(src[0]), .pad_in(pad_in), .pad(pad),
		.grant_blocked(grant_blocked));

	pfsu_pad_model pins (.sys_clk(sys_clk), .pad(pad), .pad_in(pad_in));

	// ****************************************************************
	// Checking and bus tasks.
	// ****************************************************************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is seen at an edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Pads follow the select one edge late, so let two edges pass first.
	task pads(input logic [4:0] sel, input logic [4:0] go, input logic [4:0] oe);
		pfsu_pad_t [4:0] e;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		for (int i = 0; i < 5; i++)
			e[i] = sel[i] ? '{go[i], oe[i], 1'b1} : '{src[i], 1'b1, 1'b0};
		chk("pads", {17'h0, pad}, {17'h0, e});
		chk("grant_blocked", {30'h0, grant_blocked}, {30'h0, sel[1:0]});
		@(posedge sys_clk);
	endtask

	task test_done;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and test sequence.
	// ****************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// The sequence needs about 80 cycles; this leaves a wide margin.
	initial
	begin
		#20000;
		n_fail++;
		test_done;
	end

	initial
	begin
		rst = 1'b1;
		apb_req = '0;
		src = 5'b10110;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, `PFSU_SELECT_OFF, 32'h0);
		chk("select reset", rd, `PFSU_SELECT_RST);
		chk("select err", {31'h0, er}, 32'h0);
		pads(5'h00, 5'h00, 5'h00);
		src <= 5'b01001;
		pads(5'h00, 5'h00, 5'h00);
		apb(1'b1, `PFSU_GP_OUT_OFF, {5'b10101, 27'h0});
		apb(1'b1, `PFSU_GP_OE_OFF, {5'b00111, 27'h0});
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, `PFSU_SELECT_OFF, 32'h1 << (27 + i));
			pads(5'h01 << i, 5'b10101, 5'b00111);
		end
		apb(1'b1, `PFSU_SELECT_OFF, 32'hFFFFFFFF);
		src <= 5'b00000;
		apb(1'b0, `PFSU_SELECT_OFF, 32'h0);
		chk("select all", rd, 32'hFFFFFFFF);
		pads(5'h1F, 5'b10101, 5'b00111);
		// Driven lines return their own level; released lines read the pull-up.
		apb(1'b0, `PFSU_GP_IN_OFF, 32'h0);
		chk("gp_in", rd, {5'b11101, 27'h0});
		apb(1'b1, `PFSU_GP_IN_OFF, 32'h0);
		apb(1'b0, `PFSU_GP_IN_OFF, 32'h0);
		chk("gp_in kept", rd, {5'b11101, 27'h0});
		apb(1'b0, 12'h058, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 12'h058, 32'h0);
		chk("unmapped wr err", {31'h0, er}, 32'h1);
		apb(1'b0, `PFSU_SELECT_OFF, 32'h0);
		chk("select kept", rd, 32'hFFFFFFFF);
		apb(1'b1, `PFSU_SELECT_OFF, 32'h0);
		pads(5'h00, 5'b10101, 5'b00111);
		test_done;
	end
endmodule
